// [dds_defines.svh]
`ifndef DDS_DEFINES_SVH
`define DDS_DEFINES_SVH

// ==========================================================
// timing counts, in distribution path cycles, except DDS_QUAL_EDGES which counts qualifier falling edges
// ==========================================================
`define DDS_QUAL_EDGES 2'h2
`define DDS_SHOT_WAIT 4'h3
`define DDS_SHOT_LEN 4'h3
`define DDS_FORCE_LOW_AT 4'h5
`define DDS_RISE_AFTER 4'h5
`define DDS_PLAIN_LAT 6

// ==========================================================
// auto sync register window and feedback select layout
// ==========================================================
`define DDS_AUTO_REG_FIRST 5'h00
`define DDS_AUTO_REG_LAST 5'h05
`define DDS_QUAL_STRIDE_SHIFT 1

`endif

// [dds_pkg.sv]
// ==========================================================
// types shared by the sync sequencer
// ==========================================================
package dds_pkg;

    // qualified sync sequence
    typedef enum logic [1:0] {
        DDS_IDLE,
        DDS_ARM,
        DDS_WAIT,
        DDS_SHOT
    } dds_state_t;

    // feedback multiplexer select code
    typedef logic [1:0] dds_fb_sel_t;

    // configuration register number on the write strobe
    typedef logic [4:0] dds_reg_addr_t;

endpackage : dds_pkg

// [dds_channel.sv]
`timescale 1ns/1ps

// ==========================================================
// one output divider with hold-low and delayed restart
// ==========================================================
module dds_channel #(
    parameter int DIV_W = 11,
    parameter int DLY_W = 5
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [DIV_W-1:0] divider_value_i,
    input wire logic [DLY_W-1:0] cycle_delay_i,
    input wire logic force_low_i,
    input wire logic release_i,
    output logic clk_o
);

    logic run_reg;
    logic wait_reg;
    logic [DLY_W-1:0] dly_reg;
    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic [DIV_W-1:0] half_w;
    logic wrap_w;
    logic start_w;

    // counter wraps at divide-1; high for the first, longer half of odd divides
    assign wrap_w = (cnt_reg >= divider_value_i - {{(DIV_W-1){1'b0}}, 1'b1});
    assign cnt_next = wrap_w ? '0 : cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
    assign half_w = (divider_value_i + {{(DIV_W-1){1'b0}}, 1'b1}) >> 1;
    // restart once the latched delay has counted out
    assign start_w = wait_reg && (dly_reg <= {{(DLY_W-1){1'b0}}, 1'b1});

    // force beats release so an overlapping plain hold keeps the pin low
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            run_reg <= 1'b1;
            wait_reg <= 1'b0;
            dly_reg <= '0;
            cnt_reg <= '0;
            clk_o <= 1'b0;
        end
        else if (force_low_i)
        begin
            run_reg <= 1'b0;
            wait_reg <= 1'b0;
            clk_o <= 1'b0;
        end
        else if (release_i)
        begin
            // R7: delay field only latched here
            wait_reg <= 1'b1;
            dly_reg <= cycle_delay_i;
        end
        else if (start_w)
        begin
            wait_reg <= 1'b0;
            run_reg <= 1'b1;
            cnt_reg <= '0;
            clk_o <= 1'b1;
        end
        else if (wait_reg)
        begin
            dly_reg <= dly_reg - {{(DLY_W-1){1'b0}}, 1'b1};
        end
        else if (run_reg)
        begin
            cnt_reg <= cnt_next;
            clk_o <= (cnt_next < half_w);
        end
    end

endmodule : dds_channel

// [dds_dynamic_delay_sync.sv]
// Contract
// R1: feedback select picks the qualifying output clock
// R2: exempt qualifier gives absolute, qualifier untouched
// R3: non-exempt qualifier gives relative, qualifier resynced
// R4: exempt outputs keep toggling through sync
// R5: host prefers absolute in zero-delay mode
// R6: half step applies at once, no sync
// R7: cycle delay changes only at sync
// R8: host sets qualify enable before adjusting
// R9: host keeps output two powered when qualifying
// R10: host enables feedback mux for qualifier
// R11: global sync enable gates all sync
// R12: auto sync on writes to registers 0-5
// R13: pin or polarity toggle starts sync
// R14: host special sequence for delay 13+
// R15: host disables auto sync for relative half-steps
// R16: qualified, wait 3 then 3-cycle one-shot
// R17: one-shot turns synced outputs off then on
// R18: host aligns qualifier falling edge to distribution
// R19: host sets qualifier half step per table
// R20: absolute mode leaves qualifier half step fixed
// R21: absolute adjustment may glitch the adjusted output
// R22: select 2 routes output four as qualifier
// R23: low 5 after shot start, rise 5+delay after end; a delay of 0 rises as a delay of 1
// R24: all counts in distribution clock cycles; the code counts DDS_QUAL_EDGES in qualifier falling edges instead
// R25: resample sync pin and qualifier edge first
`timescale 1ns/1ps
`include "dds_defines.svh"

module dds_dynamic_delay_sync #(
    parameter int NUM_OUT = 6,
    parameter int DIV_W = 11,
    parameter int DLY_W = 5
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic sync_pin_i,
    input wire logic sync_polarity_invert_i,
    input wire logic sync_enable_i,
    input wire logic sync_qualify_enable_i,
    input wire logic sync_auto_enable_i,
    input wire logic feedback_mux_enable_i,
    input wire dds_pkg::dds_fb_sel_t feedback_mux_select_i,
    input wire logic reg_write_strobe_i,
    input wire dds_pkg::dds_reg_addr_t reg_write_addr_i,
    input wire logic [NUM_OUT-1:0] output_sync_exempt_i,
    input wire logic [NUM_OUT-1:0] output_half_step_i,
    input wire logic [NUM_OUT-1:0][DIV_W-1:0] output_divider_value_i,
    input wire logic [NUM_OUT-1:0][DLY_W-1:0] output_cycle_delay_i,
    output logic [NUM_OUT-1:0] output_clk_o,
    output logic [NUM_OUT-1:0] output_half_step_o,
    output logic qualify_clk_o,
    output logic relative_mode_o,
    output logic one_shot_o,
    output logic sync_busy_o
);
    import dds_pkg::*;

    localparam int PLAIN_LAT = `DDS_PLAIN_LAT;
    localparam int SEL_W = $bits(dds_fb_sel_t);

    // ==========================================================
    // sync sources
    // ==========================================================
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic asserted_prev_reg;
    logic asserted_w;
    logic assert_rise_w;
    logic auto_hit_w;
    logic start_evt_w;

    // R25: two-flop resample of the asynchronous pin
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            asserted_prev_reg <= 1'b0;
        end
        else
        begin
            pin_meta_reg <= sync_pin_i;
            pin_sync_reg <= pin_meta_reg;
            asserted_prev_reg <= asserted_w;
        end
    end

    // R13: flipping either pin or polarity bit changes the asserted level
    assign asserted_w = sync_enable_i && (pin_sync_reg ^ sync_polarity_invert_i);
    assign assert_rise_w = asserted_w && !asserted_prev_reg;
    // R12: writes into the low register window fire an automatic sync
    assign auto_hit_w = sync_auto_enable_i && reg_write_strobe_i
        && (reg_write_addr_i >= `DDS_AUTO_REG_FIRST) && (reg_write_addr_i <= `DDS_AUTO_REG_LAST);
    // R11: nothing starts while the global enable is low
    assign start_evt_w = sync_enable_i && (assert_rise_w || auto_hit_w);

    // ==========================================================
    // qualifying clock selection
    // ==========================================================
    logic [SEL_W:0] qual_idx_w;
    logic qual_valid_w;
    logic qual_clk_w;
    logic qual_exempt_w;
    logic qual_prev_reg;
    logic qual_fall_w;

    // R1: select code picks every other output
    // R22: code 2 lands on output four
    assign qual_idx_w = {1'b0, feedback_mux_select_i} << `DDS_QUAL_STRIDE_SHIFT;
    assign qual_valid_w = (int'(qual_idx_w) < NUM_OUT);
    assign qual_clk_w = qual_valid_w ? output_clk_o[qual_idx_w] : 1'b0;
    assign qual_exempt_w = qual_valid_w ? output_sync_exempt_i[qual_idx_w] : 1'b1;
    // R25: the qualifier is itself a flop in this domain, so one more stage finds its edge
    assign qual_fall_w = qual_prev_reg && !qual_clk_w;

    // ==========================================================
    // qualified one-shot sequencer
    // ==========================================================
    dds_state_t state_reg;
    dds_state_t state_next;
    logic [1:0] edge_reg;
    logic [1:0] edge_next;
    logic [3:0] seq_reg;
    logic [3:0] seq_next;
    logic shot_force_w;
    logic shot_release_w;
    logic shot_on_w;

    // R24: the wait and shot counts below tick once per distribution cycle; the edge count steps on qualifier falling edges
    always_comb
    begin
        state_next = state_reg;
        edge_next = edge_reg;
        seq_next = seq_reg;
        case (state_reg)
            DDS_IDLE:
            begin
                edge_next = 2'h0;
                seq_next = 4'h0;
                // unqualified auto writes skip the edge wait
                if (start_evt_w && sync_qualify_enable_i)
                    state_next = DDS_ARM;
                else if (auto_hit_w && sync_enable_i)
                    state_next = DDS_WAIT;
            end
            DDS_ARM:
            begin
                if (qual_fall_w)
                begin
                    edge_next = edge_reg + 2'h1;
                    if (edge_reg == `DDS_QUAL_EDGES - 2'h1)
                        state_next = DDS_WAIT;
                end
            end
            DDS_WAIT:
            begin
                // R16: three cycles from qualification to the one-shot
                seq_next = seq_reg + 4'h1;
                if (seq_reg == `DDS_SHOT_WAIT - 4'h1)
                begin
                    seq_next = 4'h0;
                    state_next = DDS_SHOT;
                end
            end
            DDS_SHOT:
            begin
                seq_next = seq_reg + 4'h1;
                if (shot_release_w)
                    state_next = DDS_IDLE;
            end
            default:
            begin
                state_next = DDS_IDLE;
            end
        endcase
    end

    // R16: one-shot lasts three cycles from its start
    assign shot_on_w = (state_reg == DDS_SHOT) && (seq_reg < `DDS_SHOT_LEN);
    // R17: the shot switches synced outputs off, then back on
    // R23: low five after shot start, release five after its end
    assign shot_force_w = (state_reg == DDS_SHOT) && (seq_reg == `DDS_FORCE_LOW_AT);
    assign shot_release_w = (state_reg == DDS_SHOT) && (seq_reg == `DDS_SHOT_LEN + `DDS_RISE_AFTER);

    // state registers of the sequencer
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            state_reg <= DDS_IDLE;
            edge_reg <= 2'h0;
            seq_reg <= 4'h0;
            qual_prev_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            edge_reg <= edge_next;
            seq_reg <= seq_next;
            qual_prev_reg <= qual_clk_w;
        end
    end

    // ==========================================================
    // plain level hold when qualification is off
    // ==========================================================
    logic [PLAIN_LAT:0] plain_sr_reg;
    logic plain_force_w;
    logic plain_release_w;

    // fixed latency line; a level path, so no qualifier edge is needed
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            plain_sr_reg <= '0;
        else
            plain_sr_reg <= {plain_sr_reg[PLAIN_LAT-1:0], asserted_w && !sync_qualify_enable_i};
    end

    assign plain_force_w = plain_sr_reg[PLAIN_LAT-1];
    assign plain_release_w = !plain_sr_reg[PLAIN_LAT-1] && plain_sr_reg[PLAIN_LAT];

    // ==========================================================
    // output channels
    // ==========================================================
    logic [NUM_OUT-1:0] force_w;
    logic [NUM_OUT-1:0] release_w;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++)
        begin : g_out
            // R4: exempt outputs never see force or release
            // R2: an exempt qualifier is left running, giving absolute adjustment
            // R3: a non-exempt qualifier is resynced along with the rest
            // R21: forcing low mid-pulse may leave a glitch
            assign force_w[gi] = !output_sync_exempt_i[gi] && (shot_force_w || plain_force_w);
            assign release_w[gi] = !output_sync_exempt_i[gi] && (shot_release_w || plain_release_w);

            // R7: each channel takes its new cycle delay only on release
            dds_channel #(
                .DIV_W(DIV_W),
                .DLY_W(DLY_W)
            ) u_chan (
                .clk_i(clk_i),
                .resetn_i(resetn_i),
                .divider_value_i(output_divider_value_i[gi]),
                .cycle_delay_i(output_cycle_delay_i[gi]),
                .force_low_i(force_w[gi]),
                .release_i(release_w[gi]),
                .clk_o(output_clk_o[gi])
            );
        end
    endgenerate

    // ==========================================================
    // registered status outputs
    // ==========================================================
    // half step is passed straight through, never waiting for a sync;
    // no output channel takes the half step; only this registered status output carries it
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            output_half_step_o <= '0;
            qualify_clk_o <= 1'b0;
            relative_mode_o <= 1'b0;
            one_shot_o <= 1'b0;
            sync_busy_o <= 1'b0;
        end
        else
        begin
            // R6: half step follows its input next cycle
            // R20: nothing here alters the qualifier half step in absolute mode
            output_half_step_o <= output_half_step_i;
            // R1: feedback buffer carries the qualifier only when enabled
            qualify_clk_o <= feedback_mux_enable_i && qual_clk_w;
            // R3: non-exempt qualifier means self-referenced adjustment
            relative_mode_o <= !qual_exempt_w;
            one_shot_o <= shot_on_w;
            sync_busy_o <= (state_next != DDS_IDLE) || (|plain_sr_reg);
        end
    end

endmodule : dds_dynamic_delay_sync

// [dds_sync_asserts.sv]
`timescale 1ns/1ps

// ==========================================================
// sync sequencer port checks
// ==========================================================
module dds_sync_asserts #(
    parameter int NUM_OUT = 6,
    parameter int DIV_W = 11
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic sync_enable_i,
    input wire logic feedback_mux_enable_i,
    input wire dds_pkg::dds_fb_sel_t feedback_mux_select_i,
    input wire logic [NUM_OUT-1:0] output_sync_exempt_i,
    input wire logic [NUM_OUT-1:0] output_half_step_i,
    input wire logic [NUM_OUT-1:0][DIV_W-1:0] output_divider_value_i,
    input wire logic [NUM_OUT-1:0] output_clk_o,
    input wire logic [NUM_OUT-1:0] output_half_step_o,
    input wire logic qualify_clk_o,
    input wire logic relative_mode_o,
    input wire logic one_shot_o,
    input wire logic sync_busy_o
);
    import dds_pkg::*;

    // select 3 has no qualifier, so guard the index before use
    wire logic [2:0] q_idx = {feedback_mux_select_i, 1'b0};
    wire logic q_ok = feedback_mux_select_i != 2'h3;
    wire logic rel_exp = q_ok && !output_sync_exempt_i[q_idx];
    wire logic qual_exp = feedback_mux_enable_i && q_ok && output_clk_o[q_idx];
    // only a divide of two makes output zero flip on every cycle
    wire logic output_divider_value_ok = (output_divider_value_i[0] == DIV_W'(2));

    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_shot_three: assert property ($rose(one_shot_o) |-> one_shot_o[*3] ##1 !one_shot_o)
        else $error("one-shot width wrong");
    a_shot_busy: assert property (one_shot_o |-> sync_busy_o)
        else $error("one-shot outside a sequence");
    a_off_quiet: assert property (!sync_enable_i && !sync_busy_o |=> !sync_busy_o)
        else $error("sequence started while disabled");
    a_force_low: assert property ($rose(one_shot_o) |-> ##5 ((output_clk_o & ~output_sync_exempt_i) == '0)[*3])
        else $error("synced outputs not held low");
    a_busy_bound: assert property ($rose(one_shot_o) |-> ##[1:60] !sync_busy_o)
        else $error("sequence did not finish");
    a_step_now: assert property ($past(resetn_i) |-> output_half_step_o == $past(output_half_step_i))
        else $error("half step not applied at once");
    a_mode_pick: assert property ($past(resetn_i) |-> relative_mode_o == $past(rel_exp))
        else $error("adjust mode wrong");
    a_qual_follow: assert property ($past(resetn_i) |-> qualify_clk_o == $past(qual_exp))
        else $error("qualifier clock wrong");
    a_exempt_run: assert property (output_sync_exempt_i[0] && $past(output_sync_exempt_i[0]) && $past(resetn_i)
        && output_divider_value_ok |=> output_clk_o[0] != $past(output_clk_o[0]))
        else $error("exempt output interrupted");

    // main scenarios reached
    cover property ($rose(one_shot_o) && relative_mode_o);
    cover property ($rose(one_shot_o) && !relative_mode_o);
    cover property ($changed(output_half_step_o));
endmodule : dds_sync_asserts

bind dds_dynamic_delay_sync dds_sync_asserts #(.NUM_OUT(NUM_OUT), .DIV_W(DIV_W)) u_chk (
    .clk_i, .resetn_i, .sync_enable_i, .feedback_mux_enable_i, .feedback_mux_select_i,
    .output_sync_exempt_i, .output_half_step_i, .output_divider_value_i, .output_clk_o, .output_half_step_o,
    .qualify_clk_o, .relative_mode_o, .one_shot_o, .sync_busy_o
);

// [dds_host_model.sv]
`timescale 1ns/1ps

// ==========================================================
// host side driver of the sync pin and polarity bit
// ==========================================================
module dds_host_model (
    input wire logic clk_i,
    input wire logic pin_req_i,
    input wire logic pol_req_i,
    output logic sync_pin_o,
    output logic sync_polarity_invert_o
);
    logic pin_seen_reg = 1'b0;
    logic pol_seen_reg = 1'b0;

    initial
    begin
        sync_pin_o = 1'b0;
        sync_polarity_invert_o = 1'b0;
    end

    // requests are taken on the rising edge, so the bench's falling-edge writes never race the toggle
    always @(posedge clk_i)
    begin
        pin_seen_reg <= pin_req_i;
        pol_seen_reg <= pol_req_i;
    end

    // toggle pin or polarity
    // changes land on falling edges, away from the sampling edge
    always @(negedge clk_i)
    begin
        if (pin_seen_reg)
            sync_pin_o <= !sync_pin_o;
        if (pol_seen_reg)
            sync_polarity_invert_o <= !sync_polarity_invert_o;
    end
endmodule : dds_host_model

// [tb.sv]
`timescale 1ns/1ps

// ==========================================================
// self-checking bench for the sync sequencer
// ==========================================================
module tb;
    import dds_pkg::*;
    localparam int N = 6;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic pin_req = 1'b0;
    logic pol_req = 1'b0;
    logic sync_pin;
    logic sync_pol;
    logic sync_en = 1'b1;
    logic qual_en = 1'b1;
    logic auto_en = 1'b0;
    logic fb_en = 1'b1;
    dds_fb_sel_t fb_sel = 2'h2;
    logic wr_stb = 1'b0;
    dds_reg_addr_t wr_addr = 5'h00;
    logic [N-1:0] exempt = 6'h11;
    logic [N-1:0] hs_in = '0;
    logic [N-1:0][10:0] div = '0;
    logic [N-1:0][4:0] dly = '0;
    logic [N-1:0] out_clk;
    logic [N-1:0] hs_out;
    logic q_clk;
    logic rel_mode;
    logic shot;
    logic busy;
    logic prev_q;
    int err_count = 0;
    int check_count = 0;
    integer seed = 32'hF26FFBEB;

    always #2.5 clk_i = ~clk_i;

    dds_host_model host (.clk_i(clk_i), .pin_req_i(pin_req), .pol_req_i(pol_req),
        .sync_pin_o(sync_pin), .sync_polarity_invert_o(sync_pol));

    dds_dynamic_delay_sync #(.NUM_OUT(N)) dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .sync_pin_i(sync_pin), .sync_polarity_invert_i(sync_pol),
        .sync_enable_i(sync_en), .sync_qualify_enable_i(qual_en), .sync_auto_enable_i(auto_en),
        .feedback_mux_enable_i(fb_en), .feedback_mux_select_i(fb_sel), .reg_write_strobe_i(wr_stb),
        .reg_write_addr_i(wr_addr), .output_sync_exempt_i(exempt), .output_half_step_i(hs_in),
        .output_divider_value_i(div), .output_cycle_delay_i(dly), .output_clk_o(out_clk),
        .output_half_step_o(hs_out), .qualify_clk_o(q_clk), .relative_mode_o(rel_mode),
        .one_shot_o(shot), .sync_busy_o(busy));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    // counted from the first cycle the one-shot shows: its 3 cycles, then 5, then the delay (0 counts as 1)
    function automatic int rise_at(input logic [4:0] d);
        return 3 + 5 + ((d == 5'h00) ? 1 : int'(d));
    endfunction : rise_at

    // kind 0 pin, 1 polarity, 2 register write; go says a sequence is due
    task automatic sync_once(input int kind, input logic [4:0] addr, input logic go);
        int n;
        logic [4:0] d;
        d = 5'($unsigned($random(seed)) % 13);
        @(negedge clk_i);
        dly[2] = d;
        // align qualifier falling edge
        // qualifier half step: below 1.8 GHz, odd divide needs 1
        hs_in[2*fb_sel] = div[2*fb_sel][0];
        pin_req = (kind == 0);
        pol_req = (kind == 1);
        wr_stb = (kind == 2);
        wr_addr = addr;
        @(negedge clk_i);
        pin_req = 1'b0;
        pol_req = 1'b0;
        wr_stb = 1'b0;
        n = 0;
        while (!shot && n < 100)
        begin
            @(negedge clk_i);
            n++;
        end
        check({31'h0, shot}, {31'h0, go});
        check({31'h0, rel_mode}, {31'h0, !exempt[2*fb_sel]});
        if (shot)
        begin
            check({31'h0, busy}, 32'h1);
            n = 0;
            do
            begin
                @(negedge clk_i);
                n++;
            end while (!(out_clk[2] && n > 5) && n < 80);
            check(n, rise_at(d));
        end
        n = 0;
        while (busy && n < 100)
        begin
            @(negedge clk_i);
            n++;
        end
        check({31'h0, busy}, 32'h0);
        // put the asserted level back, which starts nothing
        pin_req = (kind == 0);
        pol_req = (kind == 1);
        @(negedge clk_i);
        pin_req = 1'b0;
        pol_req = 1'b0;
        repeat (12) @(negedge clk_i);
    endtask : sync_once

    // ==========================================================
    // main sequence
    // ==========================================================
    initial
    begin
        for (int i = 1; i < N; i++)
            div[i] = 11'(2 + $unsigned($random(seed)) % 10);
        div[0] = 11'h2;
        repeat (2) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge clk_i);
        hs_in[3] = 1'b1;
        @(negedge clk_i);
        check({31'h0, hs_out[3]}, 32'h1);
        // feedback buffer follows the selected output
        for (int i = 0; i < 24; i++)
        begin
            fb_sel = 2'($random(seed));
            fb_en = 1'($random(seed));
            prev_q = fb_en && fb_sel != 2'h3 && out_clk[2*fb_sel];
            @(negedge clk_i);
            check({31'h0, q_clk}, {31'h0, prev_q});
        end
        fb_en = 1'b1;
        // absolute mode favoured
        // auto sync only in absolute mode, where the half step stays fixed
        for (int r = 0; r < 9; r++)
        begin
            fb_sel = (r % 3 == 2) ? 2'h2 : 2'(1 + (r / 3) % 2);
            auto_en = (r % 3 == 2);
            sync_once(r % 3, 5'($unsigned($random(seed)) % 6), 1'b1);
        end
        sync_once(2, 5'h06, 1'b0);
        auto_en = 1'b0;
        sync_once(2, 5'h03, 1'b0);
        sync_en = 1'b0;
        sync_once(0, 5'h00, 1'b0);
        sync_en = 1'b1;
        // plain level sync: output two held low while asserted, no one-shot, back after release
        qual_en = 1'b0;
        pin_req = 1'b1;
        @(negedge clk_i);
        pin_req = 1'b0;
        repeat (12) @(negedge clk_i);
        check({31'h0, out_clk[2]}, 32'h0);
        check({31'h0, shot}, 32'h0);
        pin_req = 1'b1;
        @(negedge clk_i);
        pin_req = 1'b0;
        for (int i = 0; i < 40 && !out_clk[2]; i++)
            @(negedge clk_i);
        check({31'h0, out_clk[2]}, 32'h1);
        qual_en = 1'b1;
        tally_and_finish();
    end

    // watchdog well beyond the expected run length
    initial
    begin
        #100000;
        err_count++;
        tally_and_finish();
    end
endmodule : tb
